// [bench/contact_model.sv]
/*
  Contact model for the sequence pins: a closed contact pulls its pin low,
  an open one leaves it high. Assumes the bench sets the contacts just
  after a rising edge; levels change only on the clock.
*/
`timescale 1ns/1ns

module contact_model (
  input wire logic sys_clk_in,
  input wire logic [6:0] closed_in,
  output input_mapper_pkg::pin_vec_t pins_out
);
  // open lines sit at the high level, so no pin is ever left floating
  initial begin
    pins_out = 7'h7f;
  end

  // closed contact reads low
  always @(posedge sys_clk_in) begin
    pins_out <= ~closed_in;
  end
endmodule

// [bench/testbench.sv]
/*
  Self-checking bench of the input signal mapper: APB access tasks and a
  sweep of every digit code against two pin patterns.
  Assumes the register map of the constants header and a restart that applies the word.
*/
`timescale 1ns/1ns
`include "input_mapper_defs.svh"

module testbench;
  logic sys_clk_in;
  logic resetn_in;
  logic psel_in;
  logic penable_in;
  logic pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in;
  logic [31:0] prdata_out;
  logic pready_out;
  logic pslverr_out;
  logic [6:0] closed_r;
  input_mapper_pkg::pin_vec_t pins;
  wire logic [3:0] sig;
  logic [31:0] rd;
  logic [31:0] err;
  int bad_count;
  int comparisons;

  contact_model u_contacts (.sys_clk_in(sys_clk_in), .closed_in(closed_r), .pins_out(pins));

  input_signal_mapper u_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
    .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out), .sequence_io_connector_in(pins),
    .first_signal_out(sig[0]), .speed_select_a_out(sig[1]),
    .speed_select_b_out(sig[2]), .control_mode_change_out(sig[3]));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // one APB transfer; the request holds until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    // look mid-cycle where the answer has settled; only the watchdog ends a hang
    @(negedge sys_clk_in);
    while (pready_out !== 1'b1) begin
      @(negedge sys_clk_in);
    end
    rd = prdata_out;
    err = {31'h0, pslverr_out};
    // the request stands through the rising edge that samples pready high
    @(posedge sys_clk_in);
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // write a word and restart so that it takes effect
  task automatic apply(input logic [15:0] w);
    apb(1'b1, `SEL_WORD_OFFSET, {16'h0, w});
    apb(1'b1, `CONTROL_OFFSET, 32'h1);
    repeat (4) @(posedge sys_clk_in);
  endtask

  // reference mapping of one digit code onto pin levels
  function automatic logic map_bit(input logic [3:0] c, input logic [6:0] p);
    logic [3:0] k;
    k = c - `CODE_HIGH_FIRST;
    if (c <= `CODE_LOW_LAST) return ~p[c[2:0]];
    if (c == `CODE_FORCE_ON) return 1'b1;
    if (c == `CODE_FORCE_OFF) return 1'b0;
    return p[k[2:0]];
  endfunction

  task automatic stop_test;
    $display("mismatches=%0d comparisons=%0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    bad_count++;
    stop_test;
  end

  initial begin
    logic [6:0] pat [2];
    logic e;
    pat[0] = 7'h55;
    pat[1] = 7'h2a;
    resetn_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0;
    closed_r = 7'h00;
    bad_count = 0;
    comparisons = 0;
    repeat (8) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    apb(1'b0, `SEL_WORD_OFFSET, 32'h0);
    check(rd, 32'h8888);
    apb(1'b0, `ACTIVE_WORD_OFFSET, 32'h0);
    check(rd, 32'h8888);
    check({28'h0, sig}, 32'h0);
    // pin 0 low, pin 1 high, word written but not yet restarted
    closed_r <= 7'h01;
    apb(1'b1, `SEL_WORD_OFFSET, 32'hffff7a90);
    repeat (6) @(posedge sys_clk_in);
    check({28'h0, sig}, 32'h0);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    check(rd, 32'h0001_07e0);
    apb(1'b1, `ACTIVE_WORD_OFFSET, 32'h1234);
    check(err, 32'h1);
    apb(1'b0, `ACTIVE_WORD_OFFSET, 32'h0);
    check(rd, 32'h8888);
    apb(1'b0, `SEL_WORD_OFFSET, 32'h0);
    check(rd, 32'h7a90);
    apb(1'b1, `CONTROL_OFFSET, 32'h1);
    repeat (4) @(posedge sys_clk_in);
    check({28'h0, sig}, 32'hd);
    apb(1'b0, `STATUS_OFFSET, 32'h0);
    check(rd, 32'h0000_07ed);
    // every code on every digit, against two complementary pin patterns
    for (int c = 0; c < 16; c++) begin
      apply({4{c[3:0]}});
      for (int j = 0; j < 2; j++) begin
        closed_r <= ~pat[j];
        repeat (6) @(posedge sys_clk_in);
        e = map_bit(c[3:0], pat[j]);
        check({28'h0, sig}, {28'h0, {4{e}}});
      end
    end
    // second reset in mid-run: both words fall back to the idle value
    resetn_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    check({28'h0, sig}, 32'h0);
    apb(1'b0, `SEL_WORD_OFFSET, 32'h0);
    check(rd, 32'h8888);
    apb(1'b0, `ACTIVE_WORD_OFFSET, 32'h0);
    check(rd, 32'h8888);
    apb(1'b0, 12'h010, 32'h0);
    check(err, 32'h1);
    check(rd, 32'h0);
    stop_test;
  end
endmodule

// [hdl/input_mapper_defs.svh]
/*
  Constants of the input signal mapper: register offsets, field positions,
  reset values and pin counts. Assumes inclusion by bare name from the
  design files, and an APB bus with 32-bit data and byte addresses.
*/
`ifndef INPUT_MAPPER_DEFS_SVH
`define INPUT_MAPPER_DEFS_SVH

// register byte offsets
`define SEL_WORD_OFFSET 12'h000
`define ACTIVE_WORD_OFFSET 12'h004
`define CONTROL_OFFSET 12'h008
`define STATUS_OFFSET 12'h00c

// control fields
`define CTRL_RESTART_BIT 0

// status fields
`define STAT_SIG_LSB 0
`define STAT_PIN_LSB 4
`define STAT_PENDING_BIT 16

// reset value of the selection word: every digit forced deasserted
`define SEL_WORD_RESET 16'h8888

// digit codes
`define CODE_LOW_LAST 4'h6
`define CODE_FORCE_ON 4'h7
`define CODE_FORCE_OFF 4'h8
`define CODE_HIGH_FIRST 4'h9

// pin and signal counts
`define SEQ_PIN_COUNT 7
`define LOGIC_SIG_COUNT 4

`endif

// [hdl/input_mapper_pkg.sv]
/*
  Types of the input signal mapper. Assumes the constants header is
  compiled alongside; holds no process.
*/
package input_mapper_pkg;

  // one 4-bit digit of the selection word
  typedef logic [3:0] digit_t;

  // the whole 16-bit selection word
  typedef logic [15:0] select_word_t;

  // external sequence pins, first pin in bit 0
  typedef logic [6:0] pin_vec_t;

  // register selected by the bus address, one-hot
  typedef enum logic [4:0] {
    REG_SEL_WORD = 5'h01,
    REG_ACTIVE_WORD = 5'h02,
    REG_CONTROL = 5'h04,
    REG_STATUS = 5'h08,
    REG_NONE = 5'h10
  } reg_sel_t;

endpackage

// [hdl/input_signal_mapper.sv]
/*
  Input signal mapper: routes seven sequence connector pins onto four
  logical control signals under a 16-bit selection word, with an APB slave
  for the registers.
  Assumes a single 100 MHz clock, pins that are asynchronous contact levels,
  and software that issues a restart after changing the selection word.

*/
`timescale 1ns/1ns
`include "input_mapper_defs.svh"

module input_signal_mapper (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire input_mapper_pkg::pin_vec_t sequence_io_connector_in,
  output logic first_signal_out,
  output logic speed_select_a_out,
  output logic speed_select_b_out,
  output logic control_mode_change_out
);

  // map one digit code against the synchronised pins; high means asserted
  function automatic logic map_digit(input input_mapper_pkg::digit_t code,
                                     input input_mapper_pkg::pin_vec_t pins);
    logic hit;
    hit = 1'b0;
    if (code <= `CODE_LOW_LAST) begin
      hit = ~pins[code[2:0]];
    end else if (code == `CODE_FORCE_ON) begin
      hit = 1'b1;
    end else if (code == `CODE_FORCE_OFF) begin
      hit = 1'b0;
    end else begin
      hit = pins[3'(code - `CODE_HIGH_FIRST)];
    end
    return hit;
  endfunction

  input_mapper_pkg::pin_vec_t pins_s;
  input_mapper_pkg::select_word_t sel_word_r;
  input_mapper_pkg::select_word_t active_word_r;
  logic [3:0] sig_r;
  logic [3:0] sig_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pslverr_r;
  logic pslverr_nxt;
  logic restart_r;
  input_mapper_pkg::reg_sel_t reg_sel;

  // pins pass two flops before the mapper reads them
  pin_sync u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .pins_in(sequence_io_connector_in),
    .pins_sync_out(pins_s)
  );

  // address decode
  wire setup_phase = psel_in & ~penable_in;
  wire access_done = psel_in & penable_in & pready_r;
  wire wr_done = access_done & pwrite_in & ~pslverr_r;
  assign reg_sel = (paddr_in == `SEL_WORD_OFFSET) ? input_mapper_pkg::REG_SEL_WORD :
                   (paddr_in == `ACTIVE_WORD_OFFSET) ? input_mapper_pkg::REG_ACTIVE_WORD :
                   (paddr_in == `CONTROL_OFFSET) ? input_mapper_pkg::REG_CONTROL :
                   (paddr_in == `STATUS_OFFSET) ? input_mapper_pkg::REG_STATUS :
                   input_mapper_pkg::REG_NONE;
  wire wr_sel = wr_done & (reg_sel == input_mapper_pkg::REG_SEL_WORD);
  wire wr_ctrl = wr_done & (reg_sel == input_mapper_pkg::REG_CONTROL);
  wire restart_req = wr_ctrl & pwdata_in[`CTRL_RESTART_BIT];
  wire pending = (sel_word_r != active_word_r);

  // unmapped addresses and writes to read-only words answer with an error
  assign pslverr_nxt = (reg_sel == input_mapper_pkg::REG_NONE) |
                       (pwrite_in & (reg_sel == input_mapper_pkg::REG_ACTIVE_WORD)) |
                       (pwrite_in & (reg_sel == input_mapper_pkg::REG_STATUS));

  // read mux; data is captured in the setup cycle so it comes from a flop
  always_comb begin
    prdata_nxt = 32'h0000_0000;
    unique case (reg_sel)
      input_mapper_pkg::REG_SEL_WORD: prdata_nxt = {16'h0000, sel_word_r};
      input_mapper_pkg::REG_ACTIVE_WORD: prdata_nxt = {16'h0000, active_word_r};
      input_mapper_pkg::REG_CONTROL: prdata_nxt = 32'h0000_0000;
      input_mapper_pkg::REG_STATUS: begin
        prdata_nxt[`STAT_SIG_LSB +: 4] = sig_r;
        prdata_nxt[`STAT_PIN_LSB +: 7] = pins_s;
        prdata_nxt[`STAT_PENDING_BIT] = pending;
      end
      input_mapper_pkg::REG_NONE: prdata_nxt = 32'h0000_0000;
    endcase
  end

  // apb answer: ready in the first access cycle, no wait states
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= setup_phase;
      pslverr_r <= setup_phase & pslverr_nxt;
      prdata_r <= (setup_phase & ~pwrite_in) ? prdata_nxt : 32'h0000_0000;
    end
  end

  // restart only
  // the written word waits in sel_word_r; mapping keeps the old word until
  // a restart, so a half-edited word never reaches the outputs
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sel_word_r <= `SEL_WORD_RESET;
      active_word_r <= `SEL_WORD_RESET;
      restart_r <= 1'b0;
    end else begin
      restart_r <= restart_req;
      if (wr_sel) begin
        sel_word_r <= pwdata_in[15:0];
      end
      if (restart_r) begin
        active_word_r <= sel_word_r;
      end
    end
  end

  // four digits
  // each digit feeds the same table; digit 1 is the lowest nibble
  // codes 0-6 low pins, 7 and 8 forced levels, 9-15 high pins
  assign sig_nxt[0] = map_digit(active_word_r[3:0], pins_s);
  assign sig_nxt[1] = map_digit(active_word_r[7:4], pins_s);
  assign sig_nxt[2] = map_digit(active_word_r[11:8], pins_s);
  assign sig_nxt[3] = map_digit(active_word_r[15:12], pins_s);

  // mapped signals are registered so the outputs come from flops
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sig_r <= 4'h0;
    end else begin
      sig_r <= sig_nxt;
    end
  end

  // outputs
  assign prdata_out = prdata_r;
  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign first_signal_out = sig_r[0];
  assign speed_select_a_out = sig_r[1];
  assign speed_select_b_out = sig_r[2];
  assign control_mode_change_out = sig_r[3];

  // checks on the mapping and the register path
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  // digit positions map to separate signals
  digit_split_a: assert property (
    (active_word_r[7:0] == 8'h78) |=> (first_signal_out == 1'b0) && speed_select_a_out)
    else $error("low digits not routed to their own signals");

  speed_digit_a: assert property (
    (active_word_r[11:8] == 4'h7) && (active_word_r[15:12] == 4'h8)
    |=> speed_select_b_out && !control_mode_change_out)
    else $error("third or fourth digit misrouted");

  low_code_a: assert property (
    (active_word_r[3:0] <= 4'h6) |=>
    (first_signal_out == !$past(pins_s[active_word_r[2:0]])))
    else $error("low-active code gives wrong level");

  high_code_a: assert property (
    (active_word_r[7:4] >= 4'h9) |=>
    (speed_select_a_out == $past(pins_s[3'(active_word_r[7:4] - 4'h9)])))
    else $error("high-active code gives wrong level");

  mode_change_a: assert property (
    (active_word_r[15:12] == 4'h0) && !pins_s[0] |=> control_mode_change_out)
    else $error("mode change not asserted on active source");

  restart_apply_a: assert property (
    wr_sel |=> (active_word_r == $past(active_word_r)))
    else $error("selection applied without restart");

  restart_load_a: assert property (
    restart_req |-> ##2 (active_word_r == $past(sel_word_r, 1)))
    else $error("restart did not apply the pending word");

  forced_level_a: assert property (
    (active_word_r[3:0] == 4'h7) [*2] |-> first_signal_out)
    else $error("code 7 did not force the signal on");

  apb_ready_a: assert property (
    setup_phase |=> pready_out ##1 !pready_out)
    else $error("ready not a single cycle after setup");

  // each output is checked one cycle after the word and pins that fed it
  // low and high codes, other digits
  low_digit2_a: assert property (
    (active_word_r[7:4] <= 4'h6) |=>
    (speed_select_a_out == !$past(pins_s[active_word_r[6:4]])))
    else $error("second digit low-active code gives wrong level");

  low_digit3_a: assert property (
    (active_word_r[11:8] <= 4'h6) |=>
    (speed_select_b_out == !$past(pins_s[active_word_r[10:8]])))
    else $error("third digit low-active code gives wrong level");

  low_digit4_a: assert property (
    (active_word_r[15:12] <= 4'h6) |=>
    (control_mode_change_out == !$past(pins_s[active_word_r[14:12]])))
    else $error("mode change low-active code gives wrong level");

  high_digit1_a: assert property (
    (active_word_r[3:0] >= 4'h9) |=>
    (first_signal_out == $past(pins_s[3'(active_word_r[3:0] - 4'h9)])))
    else $error("first digit high-active code gives wrong level");

  high_digit3_a: assert property (
    (active_word_r[11:8] >= 4'h9) |=>
    (speed_select_b_out == $past(pins_s[3'(active_word_r[11:8] - 4'h9)])))
    else $error("third digit high-active code gives wrong level");

  high_digit4_a: assert property (
    (active_word_r[15:12] >= 4'h9) |=>
    (control_mode_change_out == $past(pins_s[3'(active_word_r[15:12] - 4'h9)])))
    else $error("mode change high-active code gives wrong level");

  forced_on_a: assert property (
    (active_word_r == 16'h7777) |=> (sig_r == 4'hf))
    else $error("code 7 did not force every signal on");

  forced_off_a: assert property (
    (active_word_r[15:4] == 12'h888) |=>
    !speed_select_a_out && !speed_select_b_out && !control_mode_change_out)
    else $error("code 8 did not force the upper signals off");

  idle_word_a: assert property (
    (active_word_r == `SEL_WORD_RESET) |=> (sig_r == 4'h0))
    else $error("reset word does not hold the signals deasserted");

  hold_word_a: assert property (
    !restart_r |=> $stable(active_word_r))
    else $error("active word changed without a restart");

  restart_pulse_a: assert property (
    restart_r |=> !restart_r)
    else $error("restart flag held longer than one cycle");

  pending_clear_a: assert property (
    restart_r |=> !pending)
    else $error("pending word still differs after restart");

  // error answers only with ready
  err_ready_a: assert property (
    pslverr_out |-> pready_out)
    else $error("error answer without ready");

  // read data stays zero outside the answer cycle
  rdata_idle_a: assert property (
    !pready_out |-> (prdata_out == 32'h0000_0000))
    else $error("read data outside the answer cycle");

  // refused transfers leave the words alone
  err_store_a: assert property (
    access_done && pslverr_r |=> $stable(sel_word_r) && $stable(active_word_r))
    else $error("refused transfer changed a selection word");

  // the active word is read-only to the bus
  ro_refuse_a: assert property (
    setup_phase && pwrite_in && (reg_sel == input_mapper_pkg::REG_ACTIVE_WORD) |=> pslverr_out)
    else $error("write to the active word not refused");

  cover_restart_c: cover property (restart_req ##2 pending == 1'b0);
  cover_low_pin_c: cover property (
    (active_word_r[3:0] == 4'h0) && !pins_s[0] ##1 first_signal_out);
  cover_high_pin_c: cover property (
    (active_word_r[7:4] == 4'hf) && pins_s[6] ##1 speed_select_a_out);
  cover_bad_addr_c: cover property (access_done && pslverr_r);
  cover_mode_high_c: cover property (
    (active_word_r[15:12] >= 4'h9) ##1 control_mode_change_out);

endmodule

// [hdl/pin_sync.sv]
/*
  Two-flop synchroniser for the external sequence pins. Assumes the pins are
  slow contact levels, asynchronous to sys_clk_in; only the second stage is
  visible to other logic.
*/
`timescale 1ns/1ns

module pin_sync (
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire input_mapper_pkg::pin_vec_t pins_in,
  output input_mapper_pkg::pin_vec_t pins_sync_out
);

  input_mapper_pkg::pin_vec_t meta_r;
  input_mapper_pkg::pin_vec_t sync_r;

  // reset to high level, which is the inactive contact state (open)
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_r <= 7'h7f;
      sync_r <= 7'h7f;
    end else begin
      meta_r <= pins_in;
      sync_r <= meta_r;
    end
  end

  assign pins_sync_out = sync_r;

endmodule
